// ===== include/t2c_defs.svh
// Constants of the timer 2 control block: offsets, bit positions, counts.
// Assumes an 8-bit register port with byte offsets.
`ifndef T2C_DEFS_SVH
`define T2C_DEFS_SVH

`define T2C_OFS_CONTROL   8'hC8
`define T2C_OFS_MODE      8'hC9
`define T2C_OFS_RELOAD_LO 8'hCA
`define T2C_OFS_RELOAD_HI 8'hCB
`define T2C_OFS_COUNT_LO  8'hCC
`define T2C_OFS_COUNT_HI  8'hCD
`define T2C_OFS_IRQ_STAT  8'hCE
`define T2C_OFS_IRQ_MASK  8'hCF

`define T2C_BIT_OVF       7
`define T2C_BIT_EXT       6
`define T2C_BIT_RXSEL     5
`define T2C_BIT_TXSEL     4
`define T2C_BIT_EXTEN     3
`define T2C_BIT_RUN       2
`define T2C_BIT_CLKSRC    1
`define T2C_BIT_CAPSEL    0
`define T2C_BIT_UPDOWN    0

`define T2C_IRQ_OVF       0
`define T2C_IRQ_EXT       1

`define T2C_RST_BYTE      8'h00
`define T2C_RST_WORD      16'h0000
`define T2C_CNT_MAX       16'hFFFF
`define T2C_PRESCALE      6
`define T2C_PRE_W         3

`endif

// ===== include/t2c_pkg.sv
// Types shared by the timer 2 control block.
// Assumes t2c_defs.svh for all numeric constants.
package t2c_pkg;
	typedef enum logic [1:0] {
		T2C_CAPTURE,
		T2C_RELOAD,
		T2C_UPDOWN,
		T2C_BAUD
	} t2c_mode_t;
	typedef logic [7:0] t2c_byte_t;
endpackage

// ===== src/t2c_timer.sv
// Timer 2 control logic: run gating, clock select, capture/reload, baud routing.
// Assumes one clock mclk_i, pins asynchronous, software on a plain strobe port.
`timescale 1ns/1ps
`include "t2c_defs.svh"

module t2c_timer #(
	parameter int PRESCALE = `T2C_PRESCALE
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic [7:0]       addr_i,
	input  wire t2c_pkg::t2c_byte_t wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output t2c_pkg::t2c_byte_t    rdata_o,
	input  wire logic             ext_trigger_pin_i,
	input  wire logic             count_input_pin_i,
	input  wire logic             timer_int_enable_i,
	input  wire logic             other_timer_ovf_i,
	output logic                  rx_baud_clk_o,
	output logic                  tx_baud_clk_o,
	output logic                  timer_irq_o,
	output logic                  irq_o
);
	import t2c_pkg::*;

	t2c_byte_t            control;
	logic                 up_down_enable;
	logic [15:0]          count;
	logic [15:0]          reload;
	logic [1:0]           irq_stat;
	logic [1:0]           irq_mask;
	logic [2:0]           trig_sync;
	logic [2:0]           cin_sync;
	logic                 trig_level;
	logic                 cin_level;
	logic [`T2C_PRE_W-1:0] pre_cnt;
	logic                 tick;
	logic                 trig_fall;
	logic                 cin_fall;
	logic                 ext_event;
	logic                 ovf_event;
	logic                 ovf_pulse;
	logic                 baud_mode;
	t2c_mode_t            mode;
	logic [15:0]          next_count;
	logic [15:0]          next_reload;
	logic                 wr_ctrl;

	assign wr_ctrl   = wr_i && (addr_i == `T2C_OFS_CONTROL);
	assign baud_mode = control[`T2C_BIT_RXSEL] | control[`T2C_BIT_TXSEL];

	always_comb begin
		if (baud_mode) begin
			mode = T2C_BAUD;
		end else if (control[`T2C_BIT_CAPSEL]) begin
			mode = T2C_CAPTURE;
		end else if (up_down_enable) begin
			mode = T2C_UPDOWN;
		end else begin
			mode = T2C_RELOAD;
		end
	end

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			trig_sync <= 3'h7;
			cin_sync  <= 3'h7;
		end else begin
			trig_sync <= {trig_sync[1:0], ext_trigger_pin_i};
			cin_sync  <= {cin_sync[1:0], count_input_pin_i};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			trig_level <= 1'b1;
			cin_level  <= 1'b1;
		end else begin
			if (trig_sync[1] == trig_sync[2]) begin
				trig_level <= trig_sync[2];
			end
			if (cin_sync[1] == cin_sync[2]) begin
				cin_level <= cin_sync[2];
			end
		end
	end

	assign trig_fall = trig_level && !trig_sync[1] && !trig_sync[2];
	assign cin_fall  = cin_level && !cin_sync[1] && !cin_sync[2];

	// Timer clock divided by six
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pre_cnt <= '0;
		end else if (pre_cnt == `T2C_PRE_W'(PRESCALE - 1)) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= pre_cnt + `T2C_PRE_W'(1);
		end
	end

	assign tick = control[`T2C_BIT_RUN] &&
		(control[`T2C_BIT_CLKSRC] ? cin_fall
			: (pre_cnt == `T2C_PRE_W'(PRESCALE - 1)));

	// Trigger pin edges act only when enabled and in capture or reload mode, not in up/down or baud mode
	assign ext_event = control[`T2C_BIT_EXTEN] && trig_fall &&
		(mode == T2C_CAPTURE || mode == T2C_RELOAD);

	always_comb begin
		next_count  = count;
		next_reload = reload;
		ovf_pulse   = 1'b0;
		ovf_event   = 1'b0;
		case (mode)
			T2C_BAUD: begin
				if (tick) begin
					if (count == `T2C_CNT_MAX) begin
						next_count = reload;
						ovf_pulse  = 1'b1;
					end else begin
						next_count = count + 16'h0001;
					end
				end
			end
			T2C_CAPTURE: begin
				if (tick) begin
					next_count = count + 16'h0001;
					ovf_event  = (count == `T2C_CNT_MAX);
				end
				if (ext_event) begin
					next_reload = count;
				end
			end
			T2C_UPDOWN: begin
				if (tick) begin
					if (trig_level) begin
						if (count == `T2C_CNT_MAX) begin
							next_count = reload;
							ovf_event  = 1'b1;
						end else begin
							next_count = count + 16'h0001;
						end
					end else if (count == reload) begin
						next_count = `T2C_CNT_MAX;
						ovf_event  = 1'b1;
					end else begin
						next_count = count - 16'h0001;
					end
				end
			end
			T2C_RELOAD: begin
				if (tick && count == `T2C_CNT_MAX) begin
					next_count = reload;
					ovf_event  = 1'b1;
				end else if (tick) begin
					next_count = count + 16'h0001;
				end
				if (ext_event) begin
					next_count = reload;
				end
			end
			default: begin
				next_count = count;
			end
		endcase
	end

	// A software write overrides only its own byte of the hardware update in the same cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			count <= `T2C_RST_WORD;
		end else if (wr_i && addr_i == `T2C_OFS_COUNT_LO) begin
			count <= {next_count[15:8], wdata_i};
		end else if (wr_i && addr_i == `T2C_OFS_COUNT_HI) begin
			count <= {wdata_i, next_count[7:0]};
		end else begin
			count <= next_count;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reload <= `T2C_RST_WORD;
		end else if (wr_i && addr_i == `T2C_OFS_RELOAD_LO) begin
			reload <= {next_reload[15:8], wdata_i};
		end else if (wr_i && addr_i == `T2C_OFS_RELOAD_HI) begin
			reload <= {wdata_i, next_reload[7:0]};
		end else begin
			reload <= next_reload;
		end
	end

	// Control byte; hardware set wins over a software clear
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			control <= `T2C_RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				control <= wdata_i;
			end
			if (ovf_event) begin
				control[`T2C_BIT_OVF] <= 1'b1;
			end
			if (ext_event) begin
				control[`T2C_BIT_EXT] <= 1'b1;
			end else if (mode == T2C_UPDOWN && ovf_event) begin
				// Toggle gives a seventeenth count bit
				control[`T2C_BIT_EXT] <= ~(wr_ctrl ? wdata_i[`T2C_BIT_EXT]
					: control[`T2C_BIT_EXT]);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			up_down_enable <= 1'b0;
			irq_mask       <= 2'h0;
		end else begin
			if (wr_i && addr_i == `T2C_OFS_MODE) begin
				up_down_enable <= wdata_i[`T2C_BIT_UPDOWN];
			end
			if (wr_i && addr_i == `T2C_OFS_IRQ_MASK) begin
				irq_mask <= wdata_i[1:0];
			end
		end
	end

	// Sticky events, cleared by reading; a new event survives the read
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			irq_stat <= 2'h0;
		end else begin
			if (rd_i && addr_i == `T2C_OFS_IRQ_STAT) begin
				irq_stat <= 2'h0;
			end
			if (ovf_event) begin
				irq_stat[`T2C_IRQ_OVF] <= 1'b1;
			end
			if (ext_event) begin
				irq_stat[`T2C_IRQ_EXT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rdata_o <= `T2C_RST_BYTE;
		end else if (rd_i) begin
			case (addr_i)
				`T2C_OFS_CONTROL:   rdata_o <= control;
				`T2C_OFS_MODE:      rdata_o <= {7'h00, up_down_enable};
				`T2C_OFS_RELOAD_LO: rdata_o <= reload[7:0];
				`T2C_OFS_RELOAD_HI: rdata_o <= reload[15:8];
				`T2C_OFS_COUNT_LO:  rdata_o <= count[7:0];
				`T2C_OFS_COUNT_HI:  rdata_o <= count[15:8];
				`T2C_OFS_IRQ_STAT:  rdata_o <= {6'h00, irq_stat};
				`T2C_OFS_IRQ_MASK:  rdata_o <= {6'h00, irq_mask};
				default:            rdata_o <= `T2C_RST_BYTE;
			endcase
		end else begin
			rdata_o <= `T2C_RST_BYTE;
		end
	end

	// Selected baud outputs are one-cycle overflow pulses; unselected ones pass other_timer_ovf_i
	assign rx_baud_clk_o = control[`T2C_BIT_RXSEL] ? ovf_pulse : other_timer_ovf_i;
	assign tx_baud_clk_o = control[`T2C_BIT_TXSEL] ? ovf_pulse : other_timer_ovf_i;
	assign timer_irq_o   = timer_int_enable_i &&
		(control[`T2C_BIT_OVF] || control[`T2C_BIT_EXT]);
	assign irq_o         = |(irq_stat & irq_mask);

endmodule // t2c_timer

// ===== testbench/t2c_pins_model.sv
// Model of the trigger pin, count pin and other timer.
// Assumes the bench calls its tasks between register accesses.
`timescale 1ns/1ps
module t2c_pins_model (
	input  wire logic mclk_i,
	output logic      ext_trigger_pin_o,
	output logic      count_input_pin_o,
	output logic      other_timer_ovf_o
);
	initial begin
		ext_trigger_pin_o = 1'b1;
		count_input_pin_o = 1'b1;
		other_timer_ovf_o = 1'b0;
	end
	// Four cycles a level, above the synchronizer minimum
	task automatic pulse_pin(input bit trig, input int n);
		repeat (n) begin
			@(posedge mclk_i);
			if (trig)
				ext_trigger_pin_o <= 1'b0;
			else
				count_input_pin_o <= 1'b0;
			repeat (4) @(posedge mclk_i);
			ext_trigger_pin_o <= 1'b1;
			count_input_pin_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
		end
	endtask
	task automatic drive_other(input bit v);
		@(posedge mclk_i) other_timer_ovf_o <= v;
	endtask
	// Level on the trigger pin sets the up/down direction
	task automatic hold_trig(input bit v);
		@(posedge mclk_i) ext_trigger_pin_o <= v;
	endtask
endmodule // t2c_pins_model

// ===== testbench/t2c_timer_assertions.sv
// Port checker of t2c_timer, bound at the foot.
// Assumes control bits 5:0 and mask bits change only by bus writes.
`timescale 1ns/1ps
`include "t2c_defs.svh"
module t2c_timer_assertions (
	input wire logic               mclk_i,
	input wire logic               rst_n_i,
	input wire logic [7:0]         addr_i,
	input wire t2c_pkg::t2c_byte_t wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire t2c_pkg::t2c_byte_t rdata_o,
	input wire logic               timer_int_enable_i,
	input wire logic               other_timer_ovf_i,
	input wire logic               rx_baud_clk_o,
	input wire logic               tx_baud_clk_o,
	input wire logic               timer_irq_o,
	input wire logic               irq_o
);
	import t2c_pkg::*;
	logic [5:0] ctl;
	logic [1:0] msk;
	// Shadows; hardware never touches these bits
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			ctl <= 6'h00;
		else if (wr_i && addr_i == `T2C_OFS_CONTROL)
			ctl <= wdata_i[5:0];
	end
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			msk <= 2'h0;
		else if (wr_i && addr_i == `T2C_OFS_IRQ_MASK)
			msk <= wdata_i[1:0];
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_rd(logic [7:0] a); rd_i && addr_i == a; endsequence
	property p_ctl_rd; s_rd(`T2C_OFS_CONTROL) |=> rdata_o[5:0] == ctl; endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
	property p_msk_rd; s_rd(`T2C_OFS_IRQ_MASK) |=> rdata_o[1:0] == msk; endproperty
	a_msk_rd: assert property (p_msk_rd) else $error("mask readback wrong");
	property p_unmap; rd_i && (addr_i < 8'hC8 || addr_i > 8'hCF) |=> rdata_o == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_irq_gate; !timer_int_enable_i |-> !timer_irq_o; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("timer irq while disabled");
	property p_rx_route; !ctl[5] |-> rx_baud_clk_o == other_timer_ovf_i; endproperty
	a_rx_route: assert property (p_rx_route) else $error("rx baud not other timer");
	property p_tx_route; !ctl[4] |-> tx_baud_clk_o == other_timer_ovf_i; endproperty
	a_tx_route: assert property (p_tx_route) else $error("tx baud not other timer");
	property p_rx_idle; ctl[5] && !ctl[2] && !$past(ctl[2]) && !$past(ctl[2], 2) |-> !rx_baud_clk_o;
	endproperty
	a_rx_idle: assert property (p_rx_idle) else $error("baud pulse while stopped");
	property p_irq_mask; msk == 2'h0 |-> !irq_o; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
endmodule // t2c_timer_assertions
bind t2c_timer t2c_timer_assertions t2c_timer_assertions_inst (.mclk_i, .rst_n_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .timer_int_enable_i, .other_timer_ovf_i,
	.rx_baud_clk_o, .tx_baud_clk_o, .timer_irq_o, .irq_o);

// ===== testbench/tb_top.sv
// Self-checking bench of the timer 2 control block.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`include "t2c_defs.svh"
module tb_top;
	import t2c_pkg::*;
	logic mclk_i, rst_n_i, wr_i, rd_i, ien, trg, cpin, oth, rxc, txc, tirq, irq;
	logic [7:0] addr_i;
	t2c_byte_t wdata_i, rdata_o;
	int fail_count = 0;
	int n_tests = 0;
	t2c_timer #(.PRESCALE(6)) t2c_timer_inst (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .ext_trigger_pin_i(trg), .count_input_pin_i(cpin),
		.timer_int_enable_i(ien), .other_timer_ovf_i(oth), .rx_baud_clk_o(rxc),
		.tx_baud_clk_o(txc), .timer_irq_o(tirq), .irq_o(irq));
	t2c_pins_model t2c_pins_model_inst (.mclk_i, .ext_trigger_pin_o(trg),
		.count_input_pin_o(cpin), .other_timer_ovf_o(oth));
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 check(rdata_o, exp);
	endtask
	// Bounded wait on irq_o or the rx baud pulse
	task automatic wait_hi(input bit rx);
		int i;
		for (i = 0; i < 200; i++) begin
			@(negedge mclk_i);
			if ((rx ? rxc : irq) === 1'b1)
				break;
		end
		if (i == 200) begin
			fail_count++;
			stop_test();
		end
	endtask
	initial begin
		{rst_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
		ien = 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(`T2C_OFS_CONTROL, 8'h00);
		wr(`T2C_OFS_IRQ_MASK, 8'h03);
		rd(`T2C_OFS_IRQ_MASK, 8'h03);
		rd(8'hC7, 8'h00);
		$display("registers done");
		wr(`T2C_OFS_RELOAD_LO, 8'hF0);
		wr(`T2C_OFS_RELOAD_HI, 8'hFF);
		wr(`T2C_OFS_COUNT_LO, 8'hFD);
		wr(`T2C_OFS_COUNT_HI, 8'hFF);
		wr(`T2C_OFS_CONTROL, 8'h04);
		wait_hi(1'b0);
		rd(`T2C_OFS_CONTROL, 8'h84);
		check({7'h00, tirq}, 8'h01);
		rd(`T2C_OFS_IRQ_STAT, 8'h01);
		rd(`T2C_OFS_IRQ_STAT, 8'h00);
		check({7'h00, irq}, 8'h00);
		wr(`T2C_OFS_CONTROL, 8'h00);
		rd(`T2C_OFS_COUNT_HI, 8'hFF);
		rd(`T2C_OFS_CONTROL, 8'h00);
		wr(`T2C_OFS_COUNT_LO, 8'h00);
		wr(`T2C_OFS_COUNT_HI, 8'h00);
		repeat (30) @(posedge mclk_i);
		rd(`T2C_OFS_COUNT_LO, 8'h00);
		$display("timer overflow done");
		wr(`T2C_OFS_CONTROL, 8'h06);
		t2c_pins_model_inst.pulse_pin(1'b0, 5);
		rd(`T2C_OFS_COUNT_LO, 8'h05);
		$display("counter mode done");
		wr(`T2C_OFS_CONTROL, 8'h05);
		t2c_pins_model_inst.pulse_pin(1'b1, 1);
		rd(`T2C_OFS_CONTROL, 8'h05);
		wr(`T2C_OFS_CONTROL, 8'h0D);
		t2c_pins_model_inst.pulse_pin(1'b1, 1);
		rd(`T2C_OFS_CONTROL, 8'h4D);
		check({7'h00, tirq}, 8'h01);
		repeat (20) @(posedge mclk_i);
		rd(`T2C_OFS_CONTROL, 8'h4D);
		rd(`T2C_OFS_IRQ_STAT, 8'h02);
		@(posedge mclk_i) ien <= 1'b0;
		@(negedge mclk_i) check({7'h00, tirq}, 8'h00);
		wr(`T2C_OFS_CONTROL, 8'h1D);
		rd(`T2C_OFS_CONTROL, 8'h1D);
		t2c_pins_model_inst.pulse_pin(1'b1, 1);
		rd(`T2C_OFS_CONTROL, 8'h1D);
		$display("trigger pin done");
		wr(`T2C_OFS_CONTROL, 8'h00);
		t2c_pins_model_inst.hold_trig(1'b0);
		wr(`T2C_OFS_MODE, 8'h01);
		wr(`T2C_OFS_RELOAD_LO, 8'h10);
		wr(`T2C_OFS_RELOAD_HI, 8'h00);
		wr(`T2C_OFS_COUNT_LO, 8'h12);
		wr(`T2C_OFS_COUNT_HI, 8'h00);
		wr(`T2C_OFS_CONTROL, 8'h04);
		wait_hi(1'b0);
		rd(`T2C_OFS_CONTROL, 8'hC4);
		rd(`T2C_OFS_COUNT_HI, 8'hFF);
		wr(`T2C_OFS_CONTROL, 8'h00);
		t2c_pins_model_inst.hold_trig(1'b1);
		wr(`T2C_OFS_MODE, 8'h00);
		rd(`T2C_OFS_IRQ_STAT, 8'h01);
		wr(`T2C_OFS_CONTROL, 8'h08);
		t2c_pins_model_inst.pulse_pin(1'b1, 1);
		rd(`T2C_OFS_COUNT_LO, 8'h10);
		rd(`T2C_OFS_CONTROL, 8'h48);
		rd(`T2C_OFS_IRQ_STAT, 8'h02);
		$display("up/down and reload trigger done");
		wr(`T2C_OFS_CONTROL, 8'h00);
		t2c_pins_model_inst.drive_other(1'b1);
		@(negedge mclk_i) check({6'h00, rxc, txc}, 8'h03);
		t2c_pins_model_inst.drive_other(1'b0);
		wr(`T2C_OFS_RELOAD_LO, 8'hFE);
		wr(`T2C_OFS_COUNT_LO, 8'hFE);
		wr(`T2C_OFS_COUNT_HI, 8'hFF);
		wr(`T2C_OFS_CONTROL, 8'h34);
		wait_hi(1'b1);
		check({7'h00, txc}, 8'h01);
		rd(`T2C_OFS_CONTROL, 8'h34);
		$display("baud routing done");
		@(posedge mclk_i) rst_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(`T2C_OFS_CONTROL, 8'h00);
		rd(`T2C_OFS_COUNT_HI, 8'h00);
		rd(`T2C_OFS_IRQ_MASK, 8'h00);
		$display("mid-run reset done");
		stop_test();
	end
endmodule // tb_top
